// *** logic/psw_params.svh ***
/*
  Constants for the peripheral select and wait-state generator: register
  offsets, field positions, block geometry and the upper register reset value.
  Assumes it is included by its bare name from the design files.
*/
`ifndef PSW_PARAMS_SVH
`define PSW_PARAMS_SVH

`define PSW_OFF_UPPER 12'h0a0
`define PSW_OFF_BASE 12'h0a4
`define PSW_OFF_MID 12'h0a8
`define PSW_OFF_STATUS 12'h0ac
`define PSW_UPPER_RESET 16'hfffb
`define PSW_BASE_HI 15
`define PSW_BASE_LO 6
`define PSW_IO_HI 15
`define PSW_IO_LO 12
`define PSW_BIT_OPT 7
`define PSW_BIT_SPACE 6
`define PSW_BIT_IGN 2
`define PSW_WAIT_HI 1
`define PSW_BLK_HI 9
`define PSW_BLK_LO 7
`define PSW_NUM_SEL 7
`define PSW_UPPER_CMP_HI 19
`define PSW_UPPER_CMP_LO 10
`define PSW_SYNC_LAT 4'h2

`endif

// *** logic/psw_pkg.sv ***
/*
  Types for the peripheral select and wait-state generator.
  Assumes psw_params.svh is available on the include path.
*/
`default_nettype none
package psw_pkg;
  // One local-bus cycle request
  typedef struct packed {
    logic valid;
    logic [19:0] addr;
    logic is_mem;
    logic internal;
  } psw_cycle_t;
  // Wait-control field
  typedef struct packed {
    logic ign_ext;
    logic [1:0] waits;
  } psw_wait_t;
  typedef enum logic [2:0] {
    PSW_IDLE = 3'b001,
    PSW_WAIT = 3'b010,
    PSW_DONE = 3'b100
  } psw_state_t;
endpackage : psw_pkg
`default_nettype wire

// *** logic/psw_ready_gen.sv ***
/*
  Wait-state sequencer for one bus cycle: counts inserted waits and
  overlaps them with external ready when that is honoured.
  Assumes ready inputs are already synchronised to pclk.
*/
`default_nettype none
`include "psw_params.svh"
module psw_ready_gen (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Cycle control
  input wire logic start,
  input wire psw_pkg::psw_wait_t wctl,
  input wire logic internal,
  input wire logic ext_ready,
  // Result
  output logic done
);
  psw_pkg::psw_state_t state;
  logic [1:0] cnt;
  logic use_ext;
  logic [3:0] held;
  logic [1:0] wait_req;

  //------------------------------------------------------------
  // Sequencer
  //------------------------------------------------------------
  // Count and external ready run in parallel; both must be satisfied when external ready is honoured, else the count alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= psw_pkg::PSW_IDLE;
      cnt <= 2'h0;
      use_ext <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        psw_pkg::PSW_IDLE: begin
          if (start) begin
            cnt <= wctl.waits;
            use_ext <= !wctl.ign_ext && !internal;
            state <= psw_pkg::PSW_WAIT;
          end
        end
        psw_pkg::PSW_WAIT: begin
          if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
          end
          // Ready seen in the first cycles still dates from before the select
          if (cnt == 2'h0 &&
              (!use_ext || (ext_ready && held >= `PSW_SYNC_LAT))) begin
            done <= 1'b1;
            state <= psw_pkg::PSW_DONE;
          end
        end
        psw_pkg::PSW_DONE: begin
          state <= psw_pkg::PSW_IDLE;
        end
        default: begin
          state <= psw_pkg::PSW_IDLE;
        end
      endcase
    end
  end

  // Helper: wait count of the cycle in flight, for the checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_req <= 2'h0;
    end else if (state == psw_pkg::PSW_IDLE && start) begin
      wait_req <= wctl.waits;
    end
  end

  // Helper: cycles spent waiting in this cycle; also gates stale ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= 4'h0;
    end else if (state == psw_pkg::PSW_IDLE) begin
      held <= 4'h0;
    end else if (held != 4'hf) begin
      held <= held + 4'h1;
    end
  end

  property p_min_waits;
    @(posedge pclk) disable iff (!presetn)
      done |-> (held > {2'b00, wait_req});
  endproperty
  a_min_waits: assert property (p_min_waits) else $error("wait count not honoured");

  property p_ignore_ready;
    @(posedge pclk) disable iff (!presetn)
      (state == psw_pkg::PSW_IDLE && start && wctl.waits == 2'h0 &&
        (wctl.ign_ext || internal)) |=> ##1 done;
  endproperty
  a_ignore_ready: assert property (p_ignore_ready) else $error("ready not ignored");

  property p_overlap;
    @(posedge pclk) disable iff (!presetn)
      (state == psw_pkg::PSW_WAIT && cnt == 2'h0 && use_ext && ext_ready &&
        held >= `PSW_SYNC_LAT) |=> done;
  endproperty
  a_overlap: assert property (p_overlap) else $error("waits added, not overlapped");
endmodule : psw_ready_gen
`default_nettype wire

// *** logic/psw_top.sv ***
/*
  Peripheral select decoder and wait-state generator with an APB register
  port. Holds the upper, base and mid control registers, decodes seven
  128-byte peripheral blocks and paces each local-bus cycle.
  Assumes the cycle request comes from logic on pclk; only ready pins are synchronised.
*/
`default_nettype none
`include "psw_params.svh"
module psw_top #(
  parameter int NUM_SEL = `PSW_NUM_SEL
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Local bus cycle from the core
  input wire logic cyc_start,
  input wire logic [19:0] cyc_addr,
  input wire logic cyc_is_mem,
  input wire logic cyc_internal,
  input wire logic async_ready_in,
  input wire logic sync_ready_in,
  // Outputs to peripherals
  output logic [NUM_SEL-1:0] peripheral_select_n,
  output logic upper_mem_select_n,
  output logic latched_a1,
  output logic latched_a2,
  output logic cyc_ready
);
  logic [15:0] upper_mem_ctrl_reg;
  logic [15:0] peripheral_base_reg;
  logic [15:0] mid_peripheral_ctrl_reg;
  logic base_seen;
  logic mid_seen;
  logic busy;
  logic periph_armed;

  //------------------------------------------------------------
  // APB register port
  //------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic hit;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign hit = paddr == `PSW_OFF_UPPER || paddr == `PSW_OFF_BASE ||
               paddr == `PSW_OFF_MID || paddr == `PSW_OFF_STATUS;

  // Single-cycle access phase, so pready is simply held high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // Registers; undefined contents of base and mid reset to zero here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_mem_ctrl_reg <= `PSW_UPPER_RESET;
      peripheral_base_reg <= 16'h0000;
      mid_peripheral_ctrl_reg <= 16'h0000;
    end else if (wr_en && pready) begin
      unique case (paddr)
        `PSW_OFF_UPPER: upper_mem_ctrl_reg <= pwdata[15:0];
        `PSW_OFF_BASE: peripheral_base_reg <= pwdata[15:0];
        `PSW_OFF_MID: mid_peripheral_ctrl_reg <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Any read or write of the base or mid register counts as an access that arms the selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_seen <= 1'b0;
      mid_seen <= 1'b0;
    end else if (psel && penable && pready) begin
      if (paddr == `PSW_OFF_BASE) begin
        base_seen <= 1'b1;
      end
      if (paddr == `PSW_OFF_MID) begin
        mid_seen <= 1'b1;
      end
    end
  end

  // Read data and error answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= !hit;
        unique case (paddr)
          `PSW_OFF_UPPER: prdata <= {16'h0000, upper_mem_ctrl_reg};
          `PSW_OFF_BASE: prdata <= {16'h0000, peripheral_base_reg};
          `PSW_OFF_MID: prdata <= {16'h0000, mid_peripheral_ctrl_reg};
          `PSW_OFF_STATUS: prdata <= {27'h0, busy, mid_seen, base_seen,
                                      periph_armed, cyc_ready};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  //------------------------------------------------------------
  // Pin synchronisers
  //------------------------------------------------------------
  logic [1:0] async_ready_in_sync;
  logic [1:0] sync_ready_in_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_ready_in_sync <= 2'b00;
      sync_ready_in_sync <= 2'b00;
    end else begin
      async_ready_in_sync <= {async_ready_in_sync[0], async_ready_in};
      sync_ready_in_sync <= {sync_ready_in_sync[0], sync_ready_in};
    end
  end
  logic ext_ready;
  assign ext_ready = async_ready_in_sync[1] || sync_ready_in_sync[1];

  //------------------------------------------------------------
  // Address decode
  //------------------------------------------------------------
  logic [19:0] peripheral_base_addr;
  logic periph_space_sel;
  logic select_count_option;
  logic in_space;
  logic [19:0] offset;
  logic in_range;
  logic [2:0] blk;
  logic upper_hit;
  assign peripheral_base_addr = {peripheral_base_reg[`PSW_BASE_HI:`PSW_BASE_LO],
                                 10'h000};
  assign periph_space_sel = mid_peripheral_ctrl_reg[`PSW_BIT_SPACE];
  assign select_count_option = mid_peripheral_ctrl_reg[`PSW_BIT_OPT];
  assign periph_armed = base_seen && mid_seen;
  assign in_space = cyc_is_mem == periph_space_sel;
  // I/O decode relies on software zeroing base bits 15..12
  assign offset = cyc_addr - peripheral_base_addr;
  assign blk = offset[`PSW_BLK_HI:`PSW_BLK_LO];
  assign in_range = cyc_addr >= peripheral_base_addr &&
                    offset[19:10] == 10'h000 && blk != 3'h7;
  assign upper_hit = cyc_is_mem && cyc_addr[`PSW_UPPER_CMP_HI:`PSW_UPPER_CMP_LO] >=
                     upper_mem_ctrl_reg[15:6];

  // Per-line select decode; blocks five and six may become address pins
  logic [NUM_SEL-1:0] next_sel;
  always_comb begin
    next_sel = '0;
    for (int i = 0; i < NUM_SEL; i++) begin
      if (cyc_start && periph_armed && in_space && in_range &&
          blk == 3'(i)) begin
        next_sel[i] = 1'b1;
      end
    end
    if (!select_count_option) begin
      next_sel[6:5] = 2'b00;
    end
  end

  // Wait field for the selected range
  psw_pkg::psw_wait_t wctl;
  always_comb begin
    if (upper_hit) begin
      wctl = upper_mem_ctrl_reg[2:0];
    end else if (blk < 3'h4) begin
      wctl = peripheral_base_reg[2:0];
    end else begin
      wctl = mid_peripheral_ctrl_reg[2:0];
    end
  end

  //------------------------------------------------------------
  // Cycle tracking and select outputs
  //------------------------------------------------------------
  logic done;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else if (cyc_start && !busy) begin
      busy <= 1'b1;
    end else if (done) begin
      busy <= 1'b0;
    end
  end

  // Selects held for the whole cycle, released with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_select_n <= '1;
      upper_mem_select_n <= 1'b1;
    end else if (cyc_start && !busy) begin
      peripheral_select_n <= ~next_sel;
      upper_mem_select_n <= !upper_hit;
    end else if (done) begin
      peripheral_select_n <= '1;
      upper_mem_select_n <= 1'b1;
    end
  end

  // Latched A1 and A2 when selects five and six are repurposed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_a1 <= 1'b1;
      latched_a2 <= 1'b1;
    end else if (cyc_start && !busy && !select_count_option) begin
      latched_a1 <= cyc_addr[1];
      latched_a2 <= cyc_addr[2];
    end
  end

  psw_ready_gen u_ready (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start && !busy),
    .wctl(wctl),
    .internal(cyc_internal),
    .ext_ready(ext_ready),
    .done(done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ready <= 1'b0;
    end else begin
      cyc_ready <= done;
    end
  end

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  property p_unarmed;
    @(posedge pclk) disable iff (!presetn)
      !periph_armed |-> ##1 (&peripheral_select_n);
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("select before arming");

  property p_block;
    @(posedge pclk) disable iff (!presetn)
      (cyc_start && !busy && periph_armed && in_space && in_range && select_count_option) |=>
        (peripheral_select_n == ~(NUM_SEL'(1) << $past(cyc_addr[`PSW_BLK_HI:`PSW_BLK_LO])));
  endproperty
  a_block: assert property (p_block) else $error("wrong select line");

  property p_space;
    @(posedge pclk) disable iff (!presetn)
      (cyc_start && !busy && !in_space) |=> (&peripheral_select_n);
  endproperty
  a_space: assert property (p_space) else $error("select in wrong space");

  property p_ex;
    @(posedge pclk) disable iff (!presetn)
      (cyc_start && !busy && !select_count_option) |=>
        (peripheral_select_n[6:5] == 2'b11 && latched_a1 == $past(cyc_addr[1]));
  endproperty
  a_ex: assert property (p_ex) else $error("A1 A2 option wrong");

  property p_align;
    @(posedge pclk) disable iff (!presetn)
      (cyc_start && !busy && periph_armed && in_space && select_count_option &&
        cyc_addr[`PSW_UPPER_CMP_HI:`PSW_UPPER_CMP_LO] ==
          peripheral_base_reg[`PSW_BASE_HI:`PSW_BASE_LO] &&
        cyc_addr[`PSW_BLK_HI:`PSW_BLK_LO] != 3'h7) |=> !(&peripheral_select_n);
  endproperty
  a_align: assert property (p_align) else $error("block at base not selected");

  // Selects stand for the whole cycle and all drop together at its end
  property p_stand;
    @(posedge pclk) disable iff (!presetn)
      (busy && !done) |=> $stable(peripheral_select_n);
  endproperty
  a_stand: assert property (p_stand) else $error("select moved mid-cycle");

  property p_release;
    @(posedge pclk) disable iff (!presetn)
      done |=> ((&peripheral_select_n) && upper_mem_select_n);
  endproperty
  a_release: assert property (p_release) else $error("select kept after cycle");

  // Top 1 KB block answers straight out of reset, before any register write
  property p_upper;
    @(posedge pclk) disable iff (!presetn)
      (upper_mem_ctrl_reg == `PSW_UPPER_RESET && cyc_start && !busy && cyc_is_mem &&
        (&cyc_addr[`PSW_UPPER_CMP_HI:`PSW_UPPER_CMP_LO])) |=> !upper_mem_select_n;
  endproperty
  a_upper: assert property (p_upper) else $error("upper block not selected");

  property p_a2;
    @(posedge pclk) disable iff (!presetn)
      (cyc_start && !busy && !select_count_option) |=> (latched_a2 == $past(cyc_addr[2]));
  endproperty
  a_a2: assert property (p_a2) else $error("A2 not latched");
endmodule : psw_top
`default_nettype wire

// *** sim/psw_periph_model.sv ***
/*
  Behavioural model of the peripherals behind the selects: answers ready
  a set number of cycles after being selected.
  Assumes the bench's pclk and presetn.
*/
`default_nettype none
module psw_periph_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Selects from the block, upper select in the top bit
  input wire logic [7:0] sel_n,
  // Scenario controls, delay ff means never ready
  input wire logic [7:0] delay,
  input wire logic hold_low,
  // Ready lines back to the block
  output logic async_ready_in,
  output logic sync_ready_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt;
  logic rdy;
  // Count cycles spent selected, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt <= 8'h00;
    else if (&sel_n)
      cnt <= 8'h00;
    else if (cnt != 8'hff)
      cnt <= cnt + 8'h01;
  end
  // Lines are pulled up while nobody is selected; hold_low stalls the bus
  assign rdy = !hold_low && ((&sel_n) || (cnt >= delay && delay != 8'hff));
  assign async_ready_in = rdy;
  assign sync_ready_in = rdy;
endmodule // psw_periph_model
`default_nettype wire

// *** sim/tb_top.sv ***
/*
  Self-checking bench: APB master, local-bus cycle driver and scenarios.
  Assumes psw_top and psw_periph_model are compiled before it.
*/
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hold;
  logic cyc_start, cyc_is_mem, cyc_internal, async_ready_in, sync_ready_in;
  logic upper_mem_select_n, la1, la2, cyc_ready, un, ca1, ca2;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] cyc_addr;
  logic [6:0] peripheral_select_n, sel;
  logic [7:0] dly;
  int num_errors, cmp_count, n, na;

  psw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cyc_start(cyc_start), .cyc_addr(cyc_addr),
    .cyc_is_mem(cyc_is_mem), .cyc_internal(cyc_internal),
    .async_ready_in(async_ready_in), .sync_ready_in(sync_ready_in),
    .peripheral_select_n(peripheral_select_n), .upper_mem_select_n(upper_mem_select_n),
    .latched_a1(la1), .latched_a2(la2), .cyc_ready(cyc_ready));
  psw_periph_model peer (.pclk(pclk), .presetn(presetn),
    .sel_n({upper_mem_select_n, peripheral_select_n}), .delay(dly), .hold_low(hold),
    .async_ready_in(async_ready_in), .sync_ready_in(sync_ready_in));

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  // One APB transfer; read data taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One local-bus cycle; n counts edges from take to the cyc_ready pulse
  task automatic cyc(input logic [19:0] a, input logic m, input logic i);
    @(posedge pclk);
    cyc_start <= 1'b1;
    cyc_addr <= a;
    cyc_is_mem <= m;
    cyc_internal <= i;
    @(posedge pclk);
    cyc_start <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
      if (n == 1) begin
        sel = peripheral_select_n;
        un = upper_mem_select_n;
        ca1 = la1;
        ca2 = la2;
      end
    end while (cyc_ready !== 1'b1 && n < 60);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Upper register defaults and an unmapped read
  task automatic t_regs;
    apb(1'b0, 12'h0a0, 32'h00000000);
    `CHK(rd, 32'h0000fffb)
    apb(1'b0, 12'h0b0, 32'h00000000);
    `CHK({err, rd}, {1'b1, 32'h00000000})
    cyc(20'hffc10, 1'b1, 1'b0);
    `CHK(un, 1'b0)
    $display("test regs done");
  endtask

  // Selects stay idle until both registers are touched
  task automatic t_arm;
    cyc(20'h00804, 1'b0, 1'b0);
    `CHK(sel, 7'h7f)
    apb(1'b1, 12'h0a4, 32'h000000bd);
    cyc(20'h00804, 1'b0, 1'b0);
    `CHK(sel, 7'h7f)
    apb(1'b1, 12'h0a8, 32'h00000087);
    cyc(20'h00804, 1'b0, 1'b0);
    `CHK(sel, 7'h7e)
    apb(1'b0, 12'h0a4, 32'h00000000);
    `CHK(rd, 32'h000000bd)
    apb(1'b0, 12'h0ac, 32'h00000000);
    `CHK(rd, 32'h0000000e)
    $display("test arm done");
  endtask

  // Base 0x00800 in I/O space, low base bits junk, waits 1 and 3 with ready ignored
  task automatic t_decode;
    for (int k = 0; k < 7; k++) begin
      cyc(20'h00804 + 20'(k * 128), 1'b0, 1'b0);
      `CHK(sel, ~(7'h01 << k))
      `CHK(n, (k < 4) ? 3 : 5)
    end
    cyc(20'h00b80, 1'b0, 1'b0);
    `CHK(sel, 7'h7f)
    cyc(20'h007fc, 1'b0, 1'b0);
    `CHK(sel, 7'h7f)
    cyc(20'h00804, 1'b1, 1'b0);
    `CHK(sel, 7'h7f)
    apb(1'b1, 12'h0a8, 32'h000000c7);
    cyc(20'h00904, 1'b1, 1'b0);
    `CHK(sel, 7'h7b)
    $display("test decode done");
  endtask

  // Option bit clear turns the two top selects into address bits
  task automatic t_option;
    apb(1'b1, 12'h0a8, 32'h00000047);
    cyc(20'h00a86, 1'b1, 1'b0);
    `CHK({ca2, ca1, sel}, {2'b11, 7'h7f})
    cyc(20'h00a82, 1'b1, 1'b0);
    `CHK({ca2, ca1}, 2'b01)
    apb(1'b1, 12'h0a8, 32'h000000c7);
    $display("test option done");
  endtask

  // Internal and external waits overlap; ignore bit and internal cycles
  task automatic t_waits;
    dly <= 8'h08;
    apb(1'b1, 12'h0a4, 32'h000000bb);
    cyc(20'h00804, 1'b1, 1'b0);
    na = n;
    apb(1'b1, 12'h0a4, 32'h000000b8);
    cyc(20'h00804, 1'b1, 1'b0);
    `CHK(n, na)
    `CHK(na > 6, 1'b1)
    hold <= 1'b1;
    apb(1'b1, 12'h0a4, 32'h000000bf);
    cyc(20'h00804, 1'b1, 1'b0);
    `CHK(n, 5)
    apb(1'b1, 12'h0a4, 32'h000000b8);
    cyc(20'h00804, 1'b1, 1'b1);
    `CHK(n, 2)
    hold <= 1'b0;
    $display("test waits done");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #60000;
    num_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    {psel, penable, pwrite, cyc_start, cyc_is_mem, cyc_internal, hold} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    cyc_addr = 20'h00000;
    dly = 8'h00;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    `CHK({upper_mem_select_n, peripheral_select_n}, 8'hff)
    @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_arm();
    t_decode();
    t_option();
    t_waits();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
